/* led_fault_diag_filter_test.sv */
// Purpose: self-checking bench of the led fault diagnosis block
// Assumes: 10 MHz core_clk, apb answers with pready
// Notes: a bench model of the filters predicts the flag register
module led_fault_diag_filter_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, meas_valid = 1'b0, pwm_settled = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [3:0] meas_ch = 4'h0;
    logic [9:0] pin_sample = 10'h000, supply_sample = 10'h000, current_sample = 10'h000;
    logic [1:0] ext_assert = 2'b00;
    wire [1:0] fault_pin_in, fault_pin_out, fault_pin_oe;
    wire [31:0] prdata;
    wire pready, pslverr, open_err_q, short_err_q;
    wire [15:0] driver_off, retry_on;
    logic [31:0] lfsr_s = 32'd83503;
    logic [7:0] cnt [16];
    logic [15:0] flg = 16'h0;
    logic seen_open = 1'b0, seen_short = 1'b0;
    int error_cnt = 0, n_compared = 0, cyc = 0, lvl = 2;
    logic [11:0] cfg_a [11] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018,
        12'h01c, 12'h020, 12'h024, 12'h028, 12'h02c};
    logic [31:0] cfg_d [11] = '{32'h2, 32'hff, 32'hff00, 32'hffff, 32'hffff, 32'hffff,
        32'h1, 32'h100, 32'h20, 32'h40, 32'h80};
    lfd_diag_top DUT (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .meas_valid, .meas_ch, .pin_sample, .supply_sample, .current_sample,
        .pwm_settled, .fault_pin_in, .fault_pin_out, .fault_pin_oe, .driver_off, .retry_on,
        .open_err_q, .short_err_q);
    lfd_fault_wire u_wire (.fault_pin_out, .fault_pin_oe, .ext_assert, .fault_pin_in);
    // free-running clock
    always #50 core_clk = ~core_clk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected {current open, voltage open, short} of one result
    function automatic logic [2:0] pred(input logic [3:0] ch, input logic [9:0] p, s, c,
        input logic st);
        logic sh, op;
        sh = st && s != 10'h3ff && (s < p || s - p < 10'h020);
        op = st && s > 10'h080 && p < 10'h100;
        return {ch > 4'h1 && c < 10'h040, op, sh};
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // one diagnosis result, bench filter model updated alongside
    task automatic meas(input logic [3:0] ch, input logic [9:0] p, s, c, input logic st);
        logic [2:0] r;
        r = pred(ch, p, s, c, st);
        meas_valid <= 1'b1;
        meas_ch <= ch;
        pin_sample <= p;
        supply_sample <= s;
        current_sample <= c;
        pwm_settled <= st;
        @(posedge core_clk);
        meas_valid <= 1'b0;
        seen_short |= r[0];
        seen_open |= r[1];
        if (|r && cnt[ch] < lvl) cnt[ch]++;
        else if (!(|r) && cnt[ch] > 0) cnt[ch]--;
        if (cnt[ch] == lvl) flg[ch] = 1'b1;
        if (cnt[ch] == 0) flg[ch] = 1'b0;
        @(posedge core_clk);
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    // main sequence
    initial begin
        foreach (cnt[i]) cnt[i] = 8'h00;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        apb(0, 12'h004, 0, rd); chk(rd, 32'h3);
        apb(0, 12'h030, 0, rd); chk(rd, 32'h0);
        apb(0, 12'h040, 0, rd); chk(rd, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 11; i++) apb(1, cfg_a[i], cfg_d[i], rd);
        for (int i = 0; i < 11; i++) begin
            apb(0, cfg_a[i], 0, rd); chk(rd, cfg_d[i]);
        end
        for (int n = 0; n < 300; n++) begin
            lfsr_s = lfsr_next(lfsr_s);
            meas(lfsr_s[3:0], lfsr_s[13:4], lfsr_s[31:30] == 2'b00 ? 10'h3ff : lfsr_s[23:14],
                lfsr_s[31:22], lfsr_s[24]);
            apb(0, 12'h030, 0, rd); chk(rd, {16'h0, flg});
        end
        $display("filter test done");
        foreach (cnt[i]) while (cnt[i] != 0) meas(4'(i), 10'h200, 10'h300, 10'h3ff, 1'b1);
        repeat (lvl) meas(4'h3, 10'h000, 10'h300, 10'h3ff, 1'b1);
        apb(1, 12'h030, 0, rd);
        apb(0, 12'h030, 0, rd); chk(rd, 32'h8);
        chk(32'(retry_on), 32'h8);
        ext_assert <= 2'b10;
        for (int m = 0; m < 16; m++) begin
            apb(1, 12'h000, m, rd);
            repeat (6) @(posedge core_clk);
            chk(32'({fault_pin_out, fault_pin_oe}), 32'({1'b0, m[0], 1'b0, m[0]}));
            chk(32'(driver_off | 16'h8), 32'({m[3] & m[2] ? 8'hff : 8'h00,
                m[1] ? 8'hff : 8'h08}));
        end
        ext_assert <= 2'b00;
        chk(32'(retry_on), 32'h0);
        apb(0, 12'h034, 0, rd); chk(rd, 32'({seen_short, seen_open}));
        $display("fault pin test done");
        final_report();
    end
endmodule // led_fault_diag_filter_test

/* lfd_chan_filter.v */
// Purpose: one channel up/down error filter with sticky error flag
// Assumes: event pulses are one cycle wide, never both at once
// Notes: flag sets at level, clears only when the counter is back at zero
`include "lfd_defines.vh"
module lfd_chan_filter #(
    parameter CW = `LFD_CNT_W
) (
    input wire core_clk,
    input wire srst,
    input wire err_evt,
    input wire ok_evt,
    input wire [CW-1:0] level,
    output reg [CW-1:0] cnt_q,
    output reg flag_q
);
    reg [CW-1:0] cnt_d;
    reg flag_d;
    // counter step and flag update
    always @* begin
        cnt_d = cnt_q;
        flag_d = flag_q;
        if (err_evt && (cnt_q < level)) begin
            cnt_d = cnt_q + {{(CW-1){1'b0}}, 1'b1}; // R1
        end else if (ok_evt && (cnt_q != {CW{1'b0}})) begin
            cnt_d = cnt_q - {{(CW-1){1'b0}}, 1'b1}; // R2
        end
        if (cnt_d == {CW{1'b0}}) begin
            flag_d = 1'b0; // R4
        end else if (cnt_d >= level) begin
            flag_d = 1'b1; // R3
        end
    end
    // state registers
    always @(posedge core_clk) begin
        if (srst) begin
            cnt_q <= {CW{1'b0}}; // R25
            flag_q <= 1'b0; // R25
        end else begin
            cnt_q <= cnt_d;
            flag_q <= flag_d;
        end
    end
endmodule // lfd_chan_filter

/* lfd_defines.vh */
// Purpose: shared constants of the led fault diagnosis filter
// Assumes: 10-bit adc samples, 16 channels, apb word registers
// Notes: offsets are byte addresses on the apb slave
`ifndef LFD_DEFINES_VH
`define LFD_DEFINES_VH
`define LFD_NCH 16
`define LFD_ADC_W 10
`define LFD_CNT_W 8
`define LFD_ADC_MAX 10'h3ff
// register byte offsets
`define LFD_OFF_CTRL 12'h000
`define LFD_OFF_LEVEL 12'h004
`define LFD_OFF_GRP0 12'h008
`define LFD_OFF_GRP1 12'h00c
`define LFD_OFF_OPEN_EN 12'h010
`define LFD_OFF_SHORT_EN 12'h014
`define LFD_OFF_IOPEN_EN 12'h018
`define LFD_OFF_BUNDLE 12'h01c
`define LFD_OFF_OPEN_THR 12'h020
`define LFD_OFF_SHORT_THR 12'h024
`define LFD_OFF_IOPEN_THR 12'h028
`define LFD_OFF_SUPLOW 12'h02c
`define LFD_OFF_FLAGS 12'h030
`define LFD_OFF_STATUS 12'h034
// ctrl fields: bit0 sel0, bit1 slm0, bit2 sel1, bit3 slm1
`define LFD_CTRL_SEL0 0
`define LFD_CTRL_SLM0 1
`define LFD_CTRL_SEL1 2
`define LFD_CTRL_SLM1 3
// reset values
`define LFD_RST_LEVEL 8'h03
`define LFD_RST_WORD 32'h00000000
// retry on-time in cycles of core_clk
`define LFD_RETRY_CYC 8'h08
`endif

/* lfd_diag_props.sv */
// Purpose: port-level checks of the led fault diagnosis block
// Assumes: one core_clk domain, srst synchronous active high
// Notes: bound into every lfd_diag_top instance
module lfd_diag_props #(
    parameter NCH = 16,
    parameter AW = 10
) (
    input wire core_clk,
    input wire srst,
    input wire pready,
    input wire pslverr,
    input wire meas_valid,
    input wire [AW-1:0] supply_sample,
    input wire pwm_settled,
    input wire [1:0] fault_pin_out,
    input wire [1:0] fault_pin_oe,
    input wire [NCH-1:0] driver_off,
    input wire [NCH-1:0] retry_on,
    input wire open_err_q,
    input wire short_err_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // a report one or two cycles back, the only thing that may open a retry window
    sequence recent_report;
        $past(meas_valid) || $past(meas_valid, 2);
    endsequence
    // cycles of retry drive since the last report; a window may not outlast its measurement
    logic mv_q;
    logic [4:0] run_q;
    always @(posedge core_clk) begin
        mv_q <= meas_valid;
        if (srst || meas_valid || mv_q || !(|retry_on)) begin
            run_q <= 5'h00;
        end else if (run_q != 5'h1f) begin
            run_q <= run_q + 5'h01;
        end
    end
    // apb answers at once and never refuses
    a_apb_ready_ok: assert property (pready && !pslverr) else $error("apb answer not ready");
    a_reset_quiet: assert property (disable iff (1'b0) $fell(srst) |->
        driver_off == 0 && retry_on == 0 && fault_pin_oe == 0 && !open_err_q && !short_err_q)
        else $error("outputs active after reset");
    a_open_cause: assert property ($rose(open_err_q) |-> $past(meas_valid))
        else $error("open flag without a measurement");
    a_short_gated: assert property ($rose(short_err_q) |->
        $past(meas_valid && supply_sample != 10'h3ff && pwm_settled))
        else $error("short flag from a gated measurement");
    a_flags_sticky: assert property (!$past(srst) |-> !$fell(open_err_q) && !$fell(short_err_q))
        else $error("common flag cleared without reset");
    a_retry_hold: assert property (run_q <= 5'h08)
        else $error("retry window too long");
    a_retry_cause: assert property ($rose(|retry_on) |-> recent_report)
        else $error("retry without a report");
    a_pin_drive: assert property ((fault_pin_oe & ~fault_pin_out) == 2'b00)
        else $error("fault pin driven inactive");
endmodule // lfd_diag_props

bind lfd_diag_top lfd_diag_props #(.NCH(NCH), .AW(AW)) u_props (.core_clk, .srst, .pready,
    .pslverr, .meas_valid, .supply_sample, .pwm_settled, .fault_pin_out, .fault_pin_oe,
    .driver_off, .retry_on, .open_err_q, .short_err_q);

/* lfd_diag_top.v */
// Purpose: led open/short diagnosis, error filters, fault groups, apb registers
// Assumes: one diagnosis result per channel per pwm period via meas_valid
// Notes: fault pin inputs come from outside and are synchronised
// Functional notes
// [R1] error event increments channel counter while below common level
// [R2] good event decrements channel counter while above zero
// [R3] counter reaching level sets channel error flag, held while nonzero
// [R4] counter back at zero clears channel error flag
// [R5] sixteen separate counters share one programmable level
// [R6] all channels measured once per pwm period
// [R7] each compare result becomes one error or good event
// [R8] short: supply minus pin computed digitally, compared with short threshold
// [R9] short only if supply unsaturated, enabled, pwm valid and settled
// [R10] voltage open only if supply above minimum, enabled, pwm settled
// [R11] fault pin select 1 outputs membership-gated error flags
// [R12] two independent groups with own pin, logic and membership bits
// [R13] select 0 keeps diagnosis off pin, pin stays a current sink
// [R14] channel with active error flag goes to retry state
// [R15] single lamp mode turns off whole group on any flag
// [R16] select 1, slm 0: incoming fault state ignored
// [R17] select 1, slm 1: incoming fault turns off group drivers
// [R18] incoming fault enable is select and single lamp mode
// [R19] slm stage passes flags when 0, all ones or zeros when 1
// [R20] retry turns faulty channel on only for minimum measurement time
// [R21] current open off for bundled channels, kept for others
// [R22] open when pin sample below open threshold
// [R23] short when supply minus pin below short threshold
// [R24] common open flag when any enabled channel open
// [R25] reset clears counters and flags
`include "lfd_defines.vh"
module lfd_diag_top #(
    parameter NCH = `LFD_NCH,
    parameter AW = `LFD_ADC_W,
    parameter CW = `LFD_CNT_W
) (
    input wire core_clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire meas_valid,
    input wire [3:0] meas_ch,
    input wire [AW-1:0] pin_sample,
    input wire [AW-1:0] supply_sample,
    input wire [AW-1:0] current_sample,
    input wire pwm_settled,
    input wire [1:0] fault_pin_in,
    output reg [1:0] fault_pin_out,
    output reg [1:0] fault_pin_oe,
    output reg [NCH-1:0] driver_off,
    output reg [NCH-1:0] retry_on,
    output reg open_err_q,
    output reg short_err_q
);
    reg [3:0] ctrl_q;
    reg [CW-1:0] level_q;
    reg [NCH-1:0] grp0_q, grp1_q, open_en_q, short_en_q, iopen_en_q;
    reg [7:0] bundle_q;
    reg [AW-1:0] open_thr_q, short_thr_q, iopen_thr_q, suplow_q;
    reg [1:0] fin_s1_q, fin_s2_q;
    reg [NCH-1:0] err_evt, ok_evt;
    wire [NCH-1:0] flag;
    reg [7:0] retry_cnt_q [0:NCH-1];
    reg [NCH-1:0] was_flag_q;
    wire wr_en, rd_en, open_c, short_c, iopen_c, short_ok, open_ok, bundled;
    wire [AW-1:0] diff;
    wire [1:0] ie, slm, sel;
    wire [NCH-1:0] slm0_vec, slm1_vec, grp0_flags, grp1_flags;
    integer i;
    genvar g;

    // slm stage: passthrough or all-or-nothing vector
    function [NCH-1:0] slm_stage;
        input [NCH-1:0] flags;
        input mode;
        begin
            if (mode) begin
                slm_stage = {NCH{|flags}}; // R19
            end else begin
                slm_stage = flags; // R19
            end
        end
    endfunction

    // apb: zero wait states, unmapped reads zero, no error
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~pwrite;

    // register writes
    always @(posedge core_clk) begin
        if (srst) begin
            ctrl_q <= 4'h0;
            level_q <= `LFD_RST_LEVEL;
            grp0_q <= {NCH{1'b0}};
            grp1_q <= {NCH{1'b0}};
            open_en_q <= {NCH{1'b0}};
            short_en_q <= {NCH{1'b0}};
            iopen_en_q <= {NCH{1'b0}};
            bundle_q <= 8'h00;
            open_thr_q <= {AW{1'b0}};
            short_thr_q <= {AW{1'b0}};
            iopen_thr_q <= {AW{1'b0}};
            suplow_q <= {AW{1'b0}};
        end else if (wr_en) begin
            case (paddr)
                `LFD_OFF_CTRL: ctrl_q <= pwdata[3:0];
                `LFD_OFF_LEVEL: level_q <= pwdata[CW-1:0]; // R5
                `LFD_OFF_GRP0: grp0_q <= pwdata[NCH-1:0]; // R12
                `LFD_OFF_GRP1: grp1_q <= pwdata[NCH-1:0]; // R12
                `LFD_OFF_OPEN_EN: open_en_q <= pwdata[NCH-1:0];
                `LFD_OFF_SHORT_EN: short_en_q <= pwdata[NCH-1:0];
                `LFD_OFF_IOPEN_EN: iopen_en_q <= pwdata[NCH-1:0];
                `LFD_OFF_BUNDLE: bundle_q <= pwdata[7:0];
                `LFD_OFF_OPEN_THR: open_thr_q <= pwdata[AW-1:0];
                `LFD_OFF_SHORT_THR: short_thr_q <= pwdata[AW-1:0];
                `LFD_OFF_IOPEN_THR: iopen_thr_q <= pwdata[AW-1:0];
                `LFD_OFF_SUPLOW: suplow_q <= pwdata[AW-1:0];
                default: ;
            endcase
        end
    end

    // register reads
    always @(posedge core_clk) begin
        if (srst) begin
            prdata <= `LFD_RST_WORD;
        end else if (rd_en && !penable) begin
            case (paddr)
                `LFD_OFF_CTRL: prdata <= {28'h0000000, ctrl_q};
                `LFD_OFF_LEVEL: prdata <= {{(32-CW){1'b0}}, level_q};
                `LFD_OFF_GRP0: prdata <= {{(32-NCH){1'b0}}, grp0_q};
                `LFD_OFF_GRP1: prdata <= {{(32-NCH){1'b0}}, grp1_q};
                `LFD_OFF_OPEN_EN: prdata <= {{(32-NCH){1'b0}}, open_en_q};
                `LFD_OFF_SHORT_EN: prdata <= {{(32-NCH){1'b0}}, short_en_q};
                `LFD_OFF_IOPEN_EN: prdata <= {{(32-NCH){1'b0}}, iopen_en_q};
                `LFD_OFF_BUNDLE: prdata <= {24'h000000, bundle_q};
                `LFD_OFF_OPEN_THR: prdata <= {{(32-AW){1'b0}}, open_thr_q};
                `LFD_OFF_SHORT_THR: prdata <= {{(32-AW){1'b0}}, short_thr_q};
                `LFD_OFF_IOPEN_THR: prdata <= {{(32-AW){1'b0}}, iopen_thr_q};
                `LFD_OFF_SUPLOW: prdata <= {{(32-AW){1'b0}}, suplow_q};
                `LFD_OFF_FLAGS: prdata <= {{(32-NCH){1'b0}}, flag};
                `LFD_OFF_STATUS: prdata <= {30'h00000000, short_err_q, open_err_q};
                default: prdata <= `LFD_RST_WORD;
            endcase
        end
    end

    // compare logic for the channel being reported
    assign diff = supply_sample - pin_sample; // R8
    assign short_c = (supply_sample < pin_sample) || (diff < short_thr_q); // R23
    assign open_c = pin_sample < open_thr_q; // R22
    assign bundled = bundle_q[meas_ch[3:1]];
    assign iopen_c = current_sample < iopen_thr_q;
    assign short_ok = (supply_sample != `LFD_ADC_MAX) && short_en_q[meas_ch]
                      && pwm_settled; // R9
    assign open_ok = (supply_sample > suplow_q) && open_en_q[meas_ch]
                     && pwm_settled; // R10

    // one event per channel per period from the compare results
    always @* begin
        err_evt = {NCH{1'b0}};
        ok_evt = {NCH{1'b0}};
        if (meas_valid) begin // R6
            if ((short_ok && short_c) || (open_ok && open_c)
                || (iopen_en_q[meas_ch] && !bundled && iopen_c)) begin // R21
                err_evt[meas_ch] = 1'b1; // R7
            end else begin
                ok_evt[meas_ch] = 1'b1; // R7
            end
        end
    end

    // common status flags, reset wins over set, cleared by reset only
    always @(posedge core_clk) begin
        if (srst) begin
            open_err_q <= 1'b0;
            short_err_q <= 1'b0;
        end else if (meas_valid) begin
            if (open_ok && open_c) begin
                open_err_q <= 1'b1; // R24
            end
            if (short_ok && short_c) begin
                short_err_q <= 1'b1;
            end
        end
    end

    // per-channel filters
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            lfd_chan_filter #(
                .CW(CW)
            ) u_filt (
                .core_clk(core_clk),
                .srst(srst),
                .err_evt(err_evt[g]),
                .ok_evt(ok_evt[g]),
                .level(level_q), // R5
                .cnt_q(),
                .flag_q(flag[g])
            );
        end
    endgenerate

    // synchronise incoming fault lines
    always @(posedge core_clk) begin
        if (srst) begin
            fin_s1_q <= 2'b00;
            fin_s2_q <= 2'b00;
        end else begin
            fin_s1_q <= fault_pin_in;
            fin_s2_q <= fin_s1_q;
        end
    end

    assign sel = {ctrl_q[`LFD_CTRL_SEL1], ctrl_q[`LFD_CTRL_SEL0]};
    assign slm = {ctrl_q[`LFD_CTRL_SLM1], ctrl_q[`LFD_CTRL_SLM0]};
    assign ie = sel & slm; // R18
    assign grp0_flags = flag & grp0_q; // R11
    assign grp1_flags = flag & grp1_q; // R11
    assign slm0_vec = slm_stage(grp0_flags, slm[0]);
    assign slm1_vec = slm_stage(grp1_flags, slm[1]);

    // fault pin drive and group shutdown
    always @(posedge core_clk) begin
        if (srst) begin
            fault_pin_out <= 2'b00;
            fault_pin_oe <= 2'b00;
            driver_off <= {NCH{1'b0}};
        end else begin
            fault_pin_out[0] <= sel[0] & (|grp0_flags); // R11 R13
            fault_pin_out[1] <= sel[1] & (|grp1_flags); // R11 R13
            fault_pin_oe[0] <= sel[0] & (|grp0_flags); // R13
            fault_pin_oe[1] <= sel[1] & (|grp1_flags); // R13
            driver_off <= (slm0_vec & grp0_q) | (slm1_vec & grp1_q) // R15
                          | ({NCH{ie[0] & fin_s2_q[0]}} & grp0_q) // R16 R17
                          | ({NCH{ie[1] & fin_s2_q[1]}} & grp1_q); // R17
        end
    end

    // retry: faulty channel driven on briefly after each period report
    always @(posedge core_clk) begin
        if (srst) begin
            retry_on <= {NCH{1'b0}};
            was_flag_q <= {NCH{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                retry_cnt_q[i] <= 8'h00;
            end
        end else begin
            was_flag_q <= flag;
            for (i = 0; i < NCH; i = i + 1) begin
                if (flag[i] && (!was_flag_q[i] || ok_evt[i] || err_evt[i])) begin
                    retry_cnt_q[i] <= `LFD_RETRY_CYC; // R14
                    retry_on[i] <= 1'b1;
                end else if (retry_cnt_q[i] != 8'h00) begin
                    retry_cnt_q[i] <= retry_cnt_q[i] - 8'h01; // R20
                    retry_on[i] <= (retry_cnt_q[i] != 8'h01) && flag[i];
                end else begin
                    retry_on[i] <= 1'b0;
                end
            end
        end
    end
endmodule // lfd_diag_top

/* lfd_fault_wire.sv */
// Purpose: shared fault wires between the block and other devices
// Assumes: a released wire is pulled to the inactive low level
// Notes: ext_assert stands for a far device pulling the line
module lfd_fault_wire (
    input wire [1:0] fault_pin_out,
    input wire [1:0] fault_pin_oe,
    input wire [1:0] ext_assert,
    output wire [1:0] fault_pin_in
);
    // wired-or of own drive and far-side drive
    assign fault_pin_in = (fault_pin_oe & fault_pin_out) | ext_assert;
endmodule // lfd_fault_wire
